//--- hdl/usb_ep_tx_pkg.sv
// constants for the endpoint transmit control block
package usb_ep_tx_pkg;
    localparam logic [7:0]  EP_OFFSET      = 8'h00;
    localparam logic [7:0]  IRQ_ST_OFFSET  = 8'h04;
    localparam logic [7:0]  IRQ_CLR_OFFSET = 8'h08;
    localparam logic [7:0]  IRQ_EN_OFFSET  = 8'h0C;
    localparam int          NUM_POS        = 0;
    localparam int          STAT_POS       = 4;
    localparam int          TOG_POS        = 6;
    localparam int          DONE_POS       = 7;
    localparam int          OPT_POS        = 8;
    localparam int          TYPE_POS       = 9;
    localparam int          EP_WIDTH       = 16;
    localparam int          IRQ_BITS       = 3;
    localparam int          IRQ_DONE       = 0;
    localparam int          IRQ_SETUP      = 1;
    localparam int          IRQ_REFUSE     = 2;
    localparam logic [3:0]  NUM_RESET      = 4'h0;
    localparam logic [1:0]  STAT_RESET     = 2'h0;
    localparam logic [1:0]  TYPE_RESET     = 2'h0;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    localparam logic [1:0]  STAT_DISABLED  = 2'h0;
    localparam logic [1:0]  STAT_STALL     = 2'h1;
    localparam logic [1:0]  STAT_NAK       = 2'h2;
    localparam logic [1:0]  STAT_VALID     = 2'h3;
    localparam logic [1:0]  TYPE_BULK      = 2'h0;
    localparam logic [1:0]  TYPE_CONTROL   = 2'h1;
    localparam logic [1:0]  TYPE_ISO       = 2'h2;
    localparam logic [1:0]  TYPE_INTERRUPT = 2'h3;
    localparam logic [1:0]  ANS_IGNORE     = 2'h0;
    localparam logic [1:0]  ANS_STALL      = 2'h1;
    localparam logic [1:0]  ANS_NAK        = 2'h2;
    localparam logic [1:0]  ANS_SEND       = 2'h3;
endpackage

//--- hdl/usb_ep_tx_ctrl.sv
// transmit control of one usb endpoint with apb register port
`timescale 1ns/10ps
module usb_ep_tx_ctrl (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        TOKEN_IN,
    input  wire logic        TOKEN_SETUP,
    input  wire logic [3:0]  TOKEN_ENDP,
    input  wire logic        HOST_ACK,
    input  wire logic        PKT_SENT,
    input  wire logic        BUF_READY,
    output logic             ENDP_HIT,
    output logic      [1:0]  TX_ANSWER,
    output logic             TX_DATA1,
    output logic             TX_BUF_SEL,
    output logic             IRQ
);
    logic [3:0]  endpoint_number_field;
    logic [1:0]  tx_status;
    logic        tx_toggle_bit;
    logic        tx_transfer_done_flag;
    logic        type_option_bit;
    logic [1:0]  transfer_type_field;
    logic [2:0]  irq_status;
    logic [2:0]  irq_enable;
    logic        in_busy;
    logic        setup_phase;
    logic        wr_acc;
    logic        ep_wr;
    logic        mapped;
    logic        is_iso;
    logic        is_ctrl;
    logic        dbl_bulk;
    logic        ack_ev;
    logic        iso_ev;
    logic        in_done;
    logic        setup_ev;
    logic        refuse_ev;
    logic [2:0]  events;
    logic [15:0] ep_word;
    logic [31:0] next_rdata;

    // type decode
    assign is_iso   = transfer_type_field == usb_ep_tx_pkg::TYPE_ISO;
    assign is_ctrl  = transfer_type_field == usb_ep_tx_pkg::TYPE_CONTROL;
    assign dbl_bulk = transfer_type_field == usb_ep_tx_pkg::TYPE_BULK
                      && type_option_bit;

    // token address match
    assign ENDP_HIT = TOKEN_ENDP == endpoint_number_field;

    // handshake answer from status
    always_comb begin
        case (tx_status)
            usb_ep_tx_pkg::STAT_DISABLED: TX_ANSWER = usb_ep_tx_pkg::ANS_IGNORE;
            usb_ep_tx_pkg::STAT_STALL:    TX_ANSWER = usb_ep_tx_pkg::ANS_STALL;
            usb_ep_tx_pkg::STAT_NAK:      TX_ANSWER = usb_ep_tx_pkg::ANS_NAK;
            default:                      TX_ANSWER = usb_ep_tx_pkg::ANS_SEND;
        endcase
    end

    // transaction events
    assign setup_ev  = TOKEN_SETUP && ENDP_HIT && is_ctrl;
    assign ack_ev    = HOST_ACK && in_busy && !is_iso;
    assign iso_ev    = PKT_SENT && in_busy && is_iso;
    assign in_done   = ack_ev || iso_ev;
    assign refuse_ev = TOKEN_IN && ENDP_HIT
                       && (tx_status == usb_ep_tx_pkg::STAT_STALL
                           || tx_status == usb_ep_tx_pkg::STAT_NAK);
    always_comb begin
        events = 3'h0;
        events[usb_ep_tx_pkg::IRQ_DONE]   = in_done;
        events[usb_ep_tx_pkg::IRQ_SETUP]  = setup_ev;
        events[usb_ep_tx_pkg::IRQ_REFUSE] = refuse_ev;
    end

    // apb decode
    assign setup_phase = PSEL && !PENABLE;
    assign wr_acc      = PSEL && PENABLE && PWRITE;
    assign ep_wr       = wr_acc && PADDR == usb_ep_tx_pkg::EP_OFFSET;
    assign mapped      = PADDR == usb_ep_tx_pkg::EP_OFFSET
                         || PADDR == usb_ep_tx_pkg::IRQ_ST_OFFSET
                         || PADDR == usb_ep_tx_pkg::IRQ_CLR_OFFSET
                         || PADDR == usb_ep_tx_pkg::IRQ_EN_OFFSET;
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && !mapped;

    // in transaction in flight on this endpoint
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            in_busy <= 1'b0;
        end else if (TOKEN_IN || TOKEN_SETUP) begin
            in_busy <= TOKEN_IN && ENDP_HIT
                       && tx_status == usb_ep_tx_pkg::STAT_VALID;
        end else if (HOST_ACK || PKT_SENT) begin
            in_busy <= 1'b0;
        end
    end

    // data toggle; hardware events win over a write
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tx_toggle_bit <= 1'b0;
        end else if (setup_ev) begin
            tx_toggle_bit <= 1'b1;
        end else if (in_done) begin
            tx_toggle_bit <= !tx_toggle_bit;
        end else if (ep_wr) begin
            tx_toggle_bit <= tx_toggle_bit
                             ^ PWDATA[usb_ep_tx_pkg::TOG_POS];
        end
    end

    // transmit status
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tx_status <= usb_ep_tx_pkg::STAT_RESET;
        end else if (setup_ev) begin
            tx_status <= usb_ep_tx_pkg::STAT_NAK;
        end else if (in_done && !is_iso) begin
            if (!dbl_bulk || !BUF_READY) begin
                tx_status <= usb_ep_tx_pkg::STAT_NAK;
            end
        end else if (ep_wr) begin
            tx_status <= tx_status
                ^ PWDATA[usb_ep_tx_pkg::STAT_POS +: 2];
        end
    end

    // done flag; a set wins over a clear
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tx_transfer_done_flag <= 1'b0;
        end else if (in_done) begin
            tx_transfer_done_flag <= 1'b1;
        end else if (ep_wr && !PWDATA[usb_ep_tx_pkg::DONE_POS]) begin
            tx_transfer_done_flag <= 1'b0;
        end
    end

    // plainly written fields
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            endpoint_number_field <= usb_ep_tx_pkg::NUM_RESET;
            transfer_type_field   <= usb_ep_tx_pkg::TYPE_RESET;
            type_option_bit       <= 1'b0;
        end else if (ep_wr) begin
            endpoint_number_field <= PWDATA[usb_ep_tx_pkg::NUM_POS +: 4];
            transfer_type_field   <= PWDATA[usb_ep_tx_pkg::TYPE_POS +: 2];
            type_option_bit       <= PWDATA[usb_ep_tx_pkg::OPT_POS];
        end
    end

    // pid and buffer select toward the packet engine
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            TX_DATA1   <= 1'b0;
            TX_BUF_SEL <= 1'b0;
        end else begin
            TX_DATA1   <= !is_iso && tx_toggle_bit;
            TX_BUF_SEL <= tx_toggle_bit;
        end
    end

    // interrupt status, clear and enable
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_status <= usb_ep_tx_pkg::IRQ_RESET;
        end else if (wr_acc && PADDR == usb_ep_tx_pkg::IRQ_CLR_OFFSET) begin
            irq_status <= (irq_status & ~PWDATA[2:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_enable <= usb_ep_tx_pkg::IRQ_RESET;
        end else if (wr_acc && PADDR == usb_ep_tx_pkg::IRQ_EN_OFFSET) begin
            irq_enable <= PWDATA[2:0];
        end
    end

    assign IRQ = |(irq_status & irq_enable);

    // read data, captured in the setup phase
    always_comb begin
        ep_word = 16'h0000;
        ep_word[usb_ep_tx_pkg::NUM_POS +: 4]  = endpoint_number_field;
        ep_word[usb_ep_tx_pkg::STAT_POS +: 2] = tx_status;
        ep_word[usb_ep_tx_pkg::TOG_POS]       = tx_toggle_bit;
        ep_word[usb_ep_tx_pkg::DONE_POS]      = tx_transfer_done_flag;
        ep_word[usb_ep_tx_pkg::OPT_POS]       = type_option_bit;
        ep_word[usb_ep_tx_pkg::TYPE_POS +: 2] = transfer_type_field;
        case (PADDR)
            usb_ep_tx_pkg::EP_OFFSET:     next_rdata = {16'h0000, ep_word};
            usb_ep_tx_pkg::IRQ_ST_OFFSET: next_rdata = {29'h0, irq_status};
            usb_ep_tx_pkg::IRQ_EN_OFFSET: next_rdata = {29'h0, irq_enable};
            default:                      next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_phase && !PWRITE) begin
            PRDATA <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence in_armed_s;
        TOKEN_IN && ENDP_HIT && tx_status == usb_ep_tx_pkg::STAT_VALID
        && !TOKEN_SETUP;
    endsequence

    sequence acked_s;
        HOST_ACK && !is_iso && !TOKEN_IN && !TOKEN_SETUP && !ep_wr;
    endsequence

    sequence buf_kept_s;
        dbl_bulk && BUF_READY;
    endsequence

    setup_toggle_a: assert property (setup_ev |=> tx_toggle_bit)
        else $error("toggle not forced to one by setup");

    ack_toggle_a: assert property (
        in_armed_s ##1 acked_s |=> tx_toggle_bit != $past(tx_toggle_bit))
        else $error("toggle not inverted by host ack");

    iso_toggle_a: assert property (
        iso_ev && !setup_ev |=> tx_toggle_bit != $past(tx_toggle_bit))
        else $error("iso toggle not inverted after packet");

    nak_after_a: assert property (
        in_armed_s ##1 (acked_s and !dbl_bulk)
        |=> tx_status == usb_ep_tx_pkg::STAT_NAK)
        else $error("status not nak after in transfer");

    iso_status_a: assert property (
        iso_ev && !ep_wr && !setup_ev |=> $stable(tx_status))
        else $error("iso status changed by hardware");

    done_set_a: assert property (
        in_done |=> tx_transfer_done_flag [*1] ##0 irq_status[0])
        else $error("done flag not set");

    pid_select_a: assert property (
        is_iso |=> !TX_DATA1)
        else $error("iso endpoint sent data1");

    pid_follow_a: assert property (
        !is_iso && $stable(transfer_type_field)
        |=> TX_DATA1 == $past(tx_toggle_bit) && TX_BUF_SEL == TX_DATA1)
        else $error("pid does not follow toggle");

    write_toggle_a: assert property (
        ep_wr && !in_done && !setup_ev
        |=> tx_toggle_bit == ($past(tx_toggle_bit) ^ $past(PWDATA[6])))
        else $error("toggle write not toggle-on-one");

    write_status_a: assert property (
        ep_wr && !in_done && !setup_ev
        |=> tx_status == ($past(tx_status) ^ $past(PWDATA[5:4])))
        else $error("status write not toggle-on-one");

    answer_map_a: assert property (
        TX_ANSWER == tx_status)
        else $error("answer does not follow status");

    hit_match_a: assert property (
        ENDP_HIT == (TOKEN_ENDP == endpoint_number_field))
        else $error("endpoint match wrong");

    irq_level_a: assert property (
        IRQ == |(irq_status & irq_enable))
        else $error("interrupt level wrong");

    setup_nak_a: assert property (
        setup_ev |=> tx_status == usb_ep_tx_pkg::STAT_NAK)
        else $error("status not nak after setup");

    dbl_hold_a: assert property (
        in_armed_s ##1 (acked_s and buf_kept_s)
        |=> tx_status == $past(tx_status))
        else $error("double-buffered status changed with buffer ready");

    stray_ack_a: assert property (
        HOST_ACK && !in_busy && !setup_ev && !ep_wr
        |=> $stable(tx_toggle_bit))
        else $error("toggle inverted by unarmed ack");

    buf_sel_a: assert property (
        $changed(tx_toggle_bit) |=> TX_BUF_SEL == $past(tx_toggle_bit))
        else $error("buffer select does not follow toggle");

    done_clear_a: assert property (
        ep_wr && !PWDATA[usb_ep_tx_pkg::DONE_POS] && !in_done
        |=> !tx_transfer_done_flag)
        else $error("done flag not cleared by written zero");

    done_keep_a: assert property (
        ep_wr && PWDATA[usb_ep_tx_pkg::DONE_POS] && !in_done
        |=> $stable(tx_transfer_done_flag))
        else $error("done flag changed by written one");

    num_write_a: assert property (
        ep_wr |=> endpoint_number_field == $past(PWDATA[3:0]))
        else $error("endpoint number not written");

    type_write_a: assert property (
        ep_wr |=> transfer_type_field == $past(PWDATA[10:9]))
        else $error("transfer type not written");

    refuse_irq_a: assert property (
        refuse_ev |=> irq_status[usb_ep_tx_pkg::IRQ_REFUSE])
        else $error("refused token not flagged");

    clear_irq_a: assert property (
        wr_acc && PADDR == usb_ep_tx_pkg::IRQ_CLR_OFFSET
        && PWDATA[usb_ep_tx_pkg::IRQ_DONE] && !in_done
        |=> !irq_status[usb_ep_tx_pkg::IRQ_DONE])
        else $error("done interrupt not cleared");
endmodule

//--- bench/usb_host_model.sv
// behavioural usb host that issues tokens and handshakes
`timescale 1ns/10ps
module usb_host_model (
    input  wire logic       sys_clk,
    output logic            token_in,
    output logic            token_setup,
    output logic      [3:0] token_endp,
    output logic            host_ack,
    output logic            pkt_sent
);
    initial begin
        token_in    = 1'b0;
        token_setup = 1'b0;
        token_endp  = 4'hF;
        host_ack    = 1'b0;
        pkt_sent    = 1'b0;
    end
    // one token, then an ack or the end of an iso packet one cycle later
    task automatic xfer(input logic setup, input logic [3:0] ep,
                        input logic ack, input logic sent);
        @(posedge sys_clk);
        token_endp  <= ep;
        token_in    <= ~setup;
        token_setup <= setup;
        @(posedge sys_clk);
        token_in    <= 1'b0;
        token_setup <= 1'b0;
        token_endp  <= ~ep;
        host_ack    <= ack;
        pkt_sent    <= sent;
        @(posedge sys_clk);
        host_ack    <= 1'b0;
        pkt_sent    <= 1'b0;
    endtask
endmodule

//--- bench/usb_ep_tx_ctrl_tb.sv
// self-checking bench for the endpoint transmit control block
`timescale 1ns/10ps
module usb_ep_tx_ctrl_tb;
    localparam logic [7:0] EP  = usb_ep_tx_pkg::EP_OFFSET;
    localparam logic [7:0] IST = usb_ep_tx_pkg::IRQ_ST_OFFSET;
    localparam logic [7:0] ICL = usb_ep_tx_pkg::IRQ_CLR_OFFSET;
    localparam logic [7:0] IEN = usb_ep_tx_pkg::IRQ_EN_OFFSET;
    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        buf_ready = 1'b0;
    logic [31:0] prdata;
    logic [3:0]  token_endp;
    logic [1:0]  tx_answer;
    logic        pready, pslverr, token_in, token_setup, host_ack;
    logic        pkt_sent, endp_hit, tx_data1, tx_buf_sel, irq;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;

    always #20 sys_clk = ~sys_clk;

    usb_ep_tx_ctrl u_dut (
        .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TOKEN_IN(token_in),
        .TOKEN_SETUP(token_setup), .TOKEN_ENDP(token_endp),
        .HOST_ACK(host_ack), .PKT_SENT(pkt_sent), .BUF_READY(buf_ready),
        .ENDP_HIT(endp_hit), .TX_ANSWER(tx_answer), .TX_DATA1(tx_data1),
        .TX_BUF_SEL(tx_buf_sel), .IRQ(irq));

    usb_host_model u_host (
        .sys_clk(sys_clk), .token_in(token_in), .token_setup(token_setup),
        .token_endp(token_endp), .host_ack(host_ack), .pkt_sent(pkt_sent));

    task automatic end_of_test();
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask

    task automatic ports(input logic [1:0] ans, input logic d1,
                         input logic bsel);
        repeat (2) @(posedge sys_clk);
        check({28'h0, ans, d1, bsel}, {28'h0, tx_answer, tx_data1,
              tx_buf_sel});
    endtask

    task automatic t_reset_unmapped();
        logic [31:0] q;
        logic        e;
        rd(EP, 32'h0);
        rd(IST, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF, q, e);
        check({31'h0, e}, 32'h1);
        apb(1'b0, 8'h10, 32'h0, q, e);
        check(q, 32'h0);
        rd(EP, 32'h0);
    endtask

    task automatic t_toggle_writes();
        wr(EP, 32'h35);
        rd(EP, 32'h35);
        wr(EP, 32'h45);
        rd(EP, 32'h75);
        wr(EP, 32'h05);
        rd(EP, 32'h75);
        u_host.xfer(1'b0, 4'h6, 1'b1, 1'b0);
        rd(EP, 32'h75);
        wr(EP, 32'h45);
        ports(2'h3, 1'b0, 1'b0);
    endtask

    task automatic t_bulk_in();
        wr(IEN, 32'h7);
        rd(IEN, 32'h7);
        u_host.xfer(1'b0, 4'h5, 1'b1, 1'b0);
        ports(2'h2, 1'b1, 1'b1);
        rd(EP, 32'hE5);
        check({31'h0, irq}, 32'h1);
        wr(ICL, 32'h1);
        rd(IST, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(EP, 32'h85);
        rd(EP, 32'hE5);
        wr(EP, 32'h05);
        rd(EP, 32'h65);
    endtask

    task automatic t_setup();
        wr(EP, 32'h245);
        rd(EP, 32'h225);
        u_host.xfer(1'b1, 4'h5, 1'b0, 1'b0);
        rd(EP, 32'h265);
        rd(IST, 32'h2);
        wr(ICL, 32'h7);
    endtask

    task automatic t_iso();
        wr(EP, 32'h415);
        ports(2'h3, 1'b0, 1'b1);
        u_host.xfer(1'b0, 4'h5, 1'b0, 1'b1);
        ports(2'h3, 1'b0, 1'b0);
        rd(EP, 32'h4B5);
        wr(EP, 32'h405);
    endtask

    task automatic t_double_buffer();
        wr(EP, 32'h105);
        buf_ready <= 1'b1;
        u_host.xfer(1'b0, 4'h5, 1'b1, 1'b0);
        rd(EP, 32'h1F5);
        buf_ready <= 1'b0;
        wr(EP, 32'h105);
        u_host.xfer(1'b0, 4'h5, 1'b1, 1'b0);
        rd(EP, 32'h1A5);
    endtask

    task automatic t_stall_disable();
        wr(ICL, 32'h7);
        wr(EP, 32'h035);
        ports(2'h1, 1'b0, 1'b0);
        u_host.xfer(1'b0, 4'h5, 1'b1, 1'b0);
        rd(EP, 32'h015);
        rd(IST, 32'h4);
        wr(EP, 32'h010);
        ports(2'h0, 1'b0, 1'b0);
        check({31'h0, endp_hit}, 32'h0);
        wr(EP, 32'h00A);
        @(posedge sys_clk);
        check({31'h0, endp_hit}, 32'h1);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_unmapped();
        t_toggle_writes();
        t_bulk_in();
        t_setup();
        t_iso();
        t_double_buffer();
        t_stall_disable();
        end_of_test();
    end
endmodule
